// *** pvc_pkg.sv ***
package pvc_pkg;
   // register indices on the phy management index
   localparam logic [4:0]  REG_XOVER_CTRL   = 5'h1b;
   localparam logic [4:0]  REG_IRQ_FLAGS    = 5'h1d;
   localparam logic [4:0]  REG_IRQ_MASK     = 5'h1e;
   localparam logic [4:0]  REG_NEG_STATUS   = 5'h1f;

   // crossover/polarity control fields
   localparam int          XC_OVERRIDE_BIT  = 15;
   localparam int          XC_AUTO_EN_BIT   = 14;
   localparam int          XC_MANUAL_BIT    = 13;
   localparam int          XC_PLL_FORCE_BIT = 10;
   localparam int          XC_POLARITY_BIT  = 4;

   // interrupt flag positions
   localparam int          IRQ_NUM          = 8;
   localparam int          IRQ_ENERGY       = 7;
   localparam int          IRQ_NEG_DONE     = 6;
   localparam int          IRQ_REMOTE_FAULT = 5;
   localparam int          IRQ_LINK_DOWN    = 4;
   localparam int          IRQ_PARTNER_ACK  = 3;
   localparam int          IRQ_PAR_FAULT    = 2;
   localparam int          IRQ_PAGE_RX      = 1;
   localparam logic [7:0]  IRQ_IMPL_MASK    = 8'hfe;
   localparam logic [7:0]  IRQ_MASK_RESET   = 8'h00;

   // negotiation status fields
   localparam int          NS_DONE_BIT      = 12;
   localparam int          NS_RSV_HI        = 11;
   localparam int          NS_RSV_LO        = 5;
   localparam logic [6:0]  NS_RSV_RESET     = 7'h02;
   localparam int          NS_SPEED_HI      = 4;
   localparam int          NS_SPEED_LO      = 2;

   // resolved speed/duplex codes
   localparam logic [2:0]  SPD_10_HALF      = 3'h1;
   localparam logic [2:0]  SPD_10_FULL      = 3'h5;
   localparam logic [2:0]  SPD_100_HALF     = 3'h2;
   localparam logic [2:0]  SPD_100_FULL     = 3'h6;

   localparam logic [15:0] ZERO16           = 16'h0000;
endpackage : pvc_pkg

// *** pvc_irq_latch.sv ***
`timescale 1ns/1ps
// latching-high flags, cleared by a read, set beats clear
module pvc_irq_latch
   import pvc_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             i_mclk,
   input  wire logic             i_reset_n,
   input  wire logic [WIDTH-1:0] i_event,
   input  wire logic [WIDTH-1:0] i_impl,
   input  wire logic [WIDTH-1:0] i_init_en,
   input  wire logic [WIDTH-1:0] i_init_val,
   input  wire logic             i_clear,
   output logic      [WIDTH-1:0] o_flags
);
   import pvc_pkg::*;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_flag
         // unimplemented positions never latch
         always_ff @(posedge i_mclk or negedge i_reset_n)
         begin
            if (!i_reset_n)
               o_flags[g] <= 1'b0;
            else if (i_init_en[g])
               o_flags[g] <= i_init_val[g] & i_impl[g];
            else if (i_event[g] & i_impl[g])
               o_flags[g] <= 1'b1;      // event wins over read-clear
            else if (i_clear)
               o_flags[g] <= 1'b0;
         end
      end
   endgenerate
endmodule : pvc_irq_latch

// *** phy_vendor_ctrl_irq_regs.sv ***
`timescale 1ns/1ps
// Overview of operation
// R1 - override bit 0 lets the strap pin pick auto crossover, 1 hands it to the register bits.
// R2 - the auto crossover enable bit counts only under override; 1 auto, 0 manual.
// R3 - manual state 0 keeps pair directions straight, 1 swaps them.
// R4 - the agent keeps manual state 0 while auto crossover is on, never all three bits set.
// R5 - the agent writes reserved control bits as zero and ignores them on read.
// R6 - the pll force bit holds the 10M receive pll on the reference, blocking 10M receive.
// R7 - a read-only bit shows received 10M polarity, 1 reversed, reset 0.
// R8 - writes to control bits 3:0 are ignored; their read value is undefined.
// R9 - flag bits 7,6,5 latch energy, negotiation done, remote fault; bits 15:8 read zero.
// R10 - flag bits 4..1 latch link down, partner ack, parallel fault, page received; bit 0 reserved.
// R11 - after reset the link-down flag takes the current line link state.
// R12 - an eight-bit mask resets to zero, 1 enables a source; upper bits read zero.
// R13 - the interrupt request is high whenever a latched flag meets a set mask bit.
// R14 - a read-only done bit is 1 once negotiation completed, else 0, reset 0.
// R15 - a three-bit field gives the resolved speed and duplex from negotiation.
// R16 - a seven-bit reserved status field resets to 0000010 and is written back as such.
module phy_vendor_ctrl_irq_regs
   import pvc_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   // management register access
   input  wire logic [4:0]  i_reg_index,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [15:0] i_reg_wdata,
   output logic      [15:0] o_reg_rdata,
   // phy core status inputs
   input  wire logic        i_crossover_auto_strap,
   input  wire logic        i_link_up,
   input  wire logic        i_energy_present,
   input  wire logic        i_rx_polarity_reversed,
   input  wire logic        i_neg_done,
   input  wire logic        i_remote_fault,
   input  wire logic        i_partner_ack,
   input  wire logic        i_parallel_fault,
   input  wire logic        i_page_rx,
   input  wire logic [2:0]  i_resolved_speed_duplex,
   // controls into the phy core, and the interrupt request
   output logic             o_crossover_auto_en,
   output logic             o_crossover_swap,
   output logic             o_rx_pll_ref_lock_force,
   output logic             o_phy_irq
);
   import pvc_pkg::*;

   // writable control state
   logic                    xover_override;
   logic                    xover_auto_en;
   logic                    xover_manual;
   logic                    rx_pll_ref_lock_force;
   logic [IRQ_NUM-1:0]      irq_mask;
   logic [6:0]              neg_rsv;
   // sampled status
   logic                    rx_polarity_reversed;
   logic                    neg_done;
   logic [2:0]              resolved_speed_duplex;
   logic                    energy_q;
   logic                    link_q;
   logic                    neg_done_q;
   logic                    init_pending;
   // flag logic
   logic [IRQ_NUM-1:0]      irq_event;
   logic [IRQ_NUM-1:0]      irq_flags;
   logic [IRQ_NUM-1:0]      init_en;
   logic [IRQ_NUM-1:0]      init_val;
   logic                    flags_clear;
   logic                    wr_xover;
   logic                    wr_mask;
   logic                    wr_status;
   logic [15:0]             next_rdata;

   assign wr_xover  = i_reg_wr && (i_reg_index == REG_XOVER_CTRL);
   assign wr_mask   = i_reg_wr && (i_reg_index == REG_IRQ_MASK);
   assign wr_status = i_reg_wr && (i_reg_index == REG_NEG_STATUS);

   // crossover and pll control; reserved bits are not stored
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         xover_override        <= 1'b0;
         xover_auto_en         <= 1'b0;
         xover_manual          <= 1'b0;
         rx_pll_ref_lock_force <= 1'b0;
      end
      else if (wr_xover)
      begin
         xover_override        <= i_reg_wdata[XC_OVERRIDE_BIT];
         xover_auto_en         <= i_reg_wdata[XC_AUTO_EN_BIT];
         xover_manual          <= i_reg_wdata[XC_MANUAL_BIT];
         rx_pll_ref_lock_force <= i_reg_wdata[XC_PLL_FORCE_BIT];   // see R6
      end
   end

   // crossover resolution; the agent keeps manual at 0 with auto on
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_crossover_auto_en <= 1'b0;
         o_crossover_swap    <= 1'b0;
      end
      else if (!xover_override)
      begin
         o_crossover_auto_en <= i_crossover_auto_strap;              // see R1
         o_crossover_swap    <= 1'b0;
      end
      else
      begin
         o_crossover_auto_en <= xover_auto_en;                       // see R1, see R2
         o_crossover_swap    <= !xover_auto_en && xover_manual;      // see R3, see R4
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_rx_pll_ref_lock_force <= 1'b0;
      else
         o_rx_pll_ref_lock_force <= rx_pll_ref_lock_force;           // see R6
   end

   // interrupt mask, upper byte not stored
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         irq_mask <= IRQ_MASK_RESET;                                 // see R12
      else if (wr_mask)
         irq_mask <= i_reg_wdata[IRQ_NUM-1:0];                       // see R12
   end

   // reserved status field holds what the agent writes back
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         neg_rsv <= NS_RSV_RESET;                                    // see R16
      else if (wr_status)
         neg_rsv <= i_reg_wdata[NS_RSV_HI:NS_RSV_LO];                // see R16
   end

   // status sampling and edge history
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rx_polarity_reversed  <= 1'b0;                              // see R7
         neg_done              <= 1'b0;                              // see R14
         resolved_speed_duplex <= 3'h0;
         energy_q              <= 1'b0;
         link_q                <= 1'b0;
         neg_done_q            <= 1'b0;
         init_pending          <= 1'b1;
      end
      else
      begin
         rx_polarity_reversed  <= i_rx_polarity_reversed;            // see R7
         neg_done              <= i_neg_done;                        // see R14
         resolved_speed_duplex <= i_resolved_speed_duplex;           // see R15
         energy_q              <= i_energy_present;
         link_q                <= i_link_up;
         neg_done_q            <= i_neg_done;
         init_pending          <= 1'b0;
      end
   end

   // event detection per source
   always_comb
   begin
      irq_event                   = '0;
      irq_event[IRQ_ENERGY]       = i_energy_present && !energy_q;   // see R9
      irq_event[IRQ_NEG_DONE]     = i_neg_done && !neg_done_q;       // see R9
      irq_event[IRQ_REMOTE_FAULT] = i_remote_fault;                  // see R9
      irq_event[IRQ_LINK_DOWN]    = !i_link_up && link_q;            // see R10
      irq_event[IRQ_PARTNER_ACK]  = i_partner_ack;                   // see R10
      irq_event[IRQ_PAR_FAULT]    = i_parallel_fault;                // see R10
      irq_event[IRQ_PAGE_RX]      = i_page_rx;                       // see R10
   end

   // link-down flag caught from the line at the first edge after reset
   always_comb
   begin
      init_en                 = '0;
      init_val                = '0;
      init_en[IRQ_LINK_DOWN]  = init_pending;                        // see R11
      init_val[IRQ_LINK_DOWN] = !i_link_up;                          // see R11
   end

   // reading the flag register clears it
   assign flags_clear = i_reg_rd && (i_reg_index == REG_IRQ_FLAGS);

   pvc_irq_latch #(
      .WIDTH      (IRQ_NUM)
   ) u_flags (
      .i_mclk     (i_mclk),
      .i_reset_n  (i_reset_n),
      .i_event    (irq_event),
      .i_impl     (IRQ_IMPL_MASK),                                   // see R10
      .i_init_en  (init_en),
      .i_init_val (init_val),
      .i_clear    (flags_clear),
      .o_flags    (irq_flags)
   );

   // request follows flags and mask with no extra latching
   assign o_phy_irq = |(irq_flags & irq_mask);                        // see R13

   // read mux; unused indices read zero
   always_comb
   begin
      next_rdata = ZERO16;
      case (i_reg_index)
         REG_XOVER_CTRL:
         begin
            next_rdata[XC_OVERRIDE_BIT]  = xover_override;
            next_rdata[XC_AUTO_EN_BIT]   = xover_auto_en;
            next_rdata[XC_MANUAL_BIT]    = xover_manual;
            next_rdata[XC_PLL_FORCE_BIT] = rx_pll_ref_lock_force;
            next_rdata[XC_POLARITY_BIT]  = rx_polarity_reversed;     // see R7
            // bits 3:0 undefined, shown as zero; see R8
         end
         REG_IRQ_FLAGS:
            next_rdata[IRQ_NUM-1:0] = irq_flags;                     // see R9
         REG_IRQ_MASK:
            next_rdata[IRQ_NUM-1:0] = irq_mask;                      // see R12
         REG_NEG_STATUS:
         begin
            next_rdata[NS_DONE_BIT]             = neg_done;          // see R14
            next_rdata[NS_RSV_HI:NS_RSV_LO]     = neg_rsv;           // see R16
            next_rdata[NS_SPEED_HI:NS_SPEED_LO] = resolved_speed_duplex;
         end
         default:
            next_rdata = ZERO16;
      endcase
   end

   // read data registered, captured on the read strobe
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_reg_rdata <= ZERO16;
      else if (i_reg_rd)
         o_reg_rdata <= next_rdata;
   end
endmodule : phy_vendor_ctrl_irq_regs

// *** pvc_mgmt_agent.sv ***
`timescale 1ns/1ps
// management agent: one register access at a time, strobes held for one edge
module pvc_mgmt_agent
   import pvc_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic [15:0] i_reg_rdata,
   output logic      [4:0]  o_reg_index,
   output logic             o_reg_wr,
   output logic             o_reg_rd,
   output logic      [15:0] o_reg_wdata
);
   // idle bus at time zero
   initial
   begin
      o_reg_index = 5'h00;
      o_reg_wr    = 1'h0;
      o_reg_rd    = 1'h0;
      o_reg_wdata = 16'h0000;
   end

   // reserved and illegal bit patterns are cleaned here, whatever a test asks
   task automatic reg_write(input logic [4:0] idx, input logic [15:0] d);
      logic [15:0] v;
      v = d;
      if (idx == REG_XOVER_CTRL)
         v = v & 16'he40f;
      if (v[15] && v[14] && idx == REG_XOVER_CTRL)
         v[13] = 1'h0;
      if (idx == REG_NEG_STATUS)
         v[11:5] = NS_RSV_RESET;
      @(posedge i_mclk);
      o_reg_index <= idx;
      o_reg_wdata <= v;
      o_reg_wr    <= 1'h1;
      @(posedge i_mclk);
      o_reg_wr    <= 1'h0;
      o_reg_wdata <= ~v;  // released data must not look valid
   endtask : reg_write

   // data is taken at the next edge while it still stands, so callers stay on edges
   task automatic reg_read(input logic [4:0] idx, output logic [15:0] d);
      @(posedge i_mclk);
      o_reg_index <= idx;
      o_reg_rd    <= 1'h1;
      @(posedge i_mclk);
      o_reg_rd    <= 1'h0;
      @(posedge i_mclk);
      d = i_reg_rdata;
   endtask : reg_read
endmodule : pvc_mgmt_agent

// *** pvc_properties.sv ***
`timescale 1ns/1ps
module pvc_checker
   import pvc_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   input  wire logic [4:0]  i_reg_index,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [15:0] i_reg_wdata,
   input  wire logic [15:0] o_reg_rdata,
   input  wire logic        i_crossover_auto_strap,
   input  wire logic        o_crossover_auto_en,
   input  wire logic        o_crossover_swap,
   input  wire logic        o_rx_pll_ref_lock_force,
   input  wire logic        o_phy_irq
);
   logic [2:0] xc;
   logic       pll;
   logic [7:0] msk;

   // mirror of the writable bits, so outputs can be tied back to writes
   always_ff @(posedge i_mclk or negedge i_reset_n)
      if (!i_reset_n)
      begin
         xc  <= 3'h0;
         pll <= 1'h0;
         msk <= 8'h00;
      end
      else if (i_reg_wr && i_reg_index == REG_XOVER_CTRL)
      begin
         xc  <= i_reg_wdata[15:13];
         pll <= i_reg_wdata[10];
      end
      else if (i_reg_wr && i_reg_index == REG_IRQ_MASK)
         msk <= i_reg_wdata[7:0];

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   chk_auto_source:
   assert property ($past(i_reset_n) |->
      o_crossover_auto_en == $past(xc[2] ? xc[1] : i_crossover_auto_strap))
      else $error("auto crossover output disagrees with override and strap");
   chk_manual_swap:
   assert property ($past(i_reset_n) |-> o_crossover_swap == $past(xc == 3'h5))
      else $error("pair swap output disagrees with manual state");
   chk_pll_force:
   assert property ($past(i_reset_n) |-> o_rx_pll_ref_lock_force == $past(pll))
      else $error("pll force output disagrees with control bit");
   chk_irq_masked:
   assert property (msk == 8'h00 |-> !o_phy_irq)
      else $error("interrupt raised with every source masked");
   chk_mask_readback:
   assert property ($past(i_reg_rd && !i_reg_wr && i_reg_index == REG_IRQ_MASK) |->
      o_reg_rdata == {8'h00, $past(msk)})
      else $error("mask read data wrong");
   chk_flag_upper:
   assert property ($past(i_reg_rd && i_reg_index == REG_IRQ_FLAGS) |->
      o_reg_rdata[15:8] == 8'h00 && !o_reg_rdata[0])
      else $error("reserved flag bits read nonzero");
   chk_status_fixed:
   assert property ($past(i_reg_rd && i_reg_index == REG_NEG_STATUS) |->
      o_reg_rdata[15:13] == 3'h0 && o_reg_rdata[11:5] == NS_RSV_RESET)
      else $error("status reserved fields wrong");
   chk_ctrl_readback:
   assert property ($past(i_reg_rd && !i_reg_wr && i_reg_index == REG_XOVER_CTRL) |->
      o_reg_rdata[15:5] == {$past(xc), 2'h0, $past(pll), 5'h00})
      else $error("control read data wrong");
   chk_rdata_hold:
   assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
      else $error("read data moved without a read");

   cov_ctrl_write: cover property (i_reg_wr && i_reg_index == REG_XOVER_CTRL);
   cov_irq_high: cover property (o_phy_irq);
   cov_swap: cover property (o_crossover_swap);
endmodule : pvc_checker

bind phy_vendor_ctrl_irq_regs pvc_checker u_chk (
   .i_mclk                  (i_mclk),
   .i_reset_n               (i_reset_n),
   .i_reg_index             (i_reg_index),
   .i_reg_wr                (i_reg_wr),
   .i_reg_rd                (i_reg_rd),
   .i_reg_wdata             (i_reg_wdata),
   .o_reg_rdata             (o_reg_rdata),
   .i_crossover_auto_strap  (i_crossover_auto_strap),
   .o_crossover_auto_en     (o_crossover_auto_en),
   .o_crossover_swap        (o_crossover_swap),
   .o_rx_pll_ref_lock_force (o_rx_pll_ref_lock_force),
   .o_phy_irq               (o_phy_irq)
);

// *** test_phy_vendor_ctrl_irq_regs.sv ***
`timescale 1ns/1ps
module test_phy_vendor_ctrl_irq_regs;
   import pvc_pkg::*;
   typedef struct {logic [15:0] wd; logic strap; logic [2:0] exp;} pvc_row_t;
   logic        i_mclk = 1'h0;
   logic        i_reset_n = 1'h0;
   logic [4:0]  idx;
   logic        wr;
   logic        rd;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [15:0] rd_val;
   logic        strap = 1'h0;
   logic        pol = 1'h0;
   logic [2:0]  spd = SPD_100_FULL;
   logic [7:0]  src = 8'h10;  // link down through reset
   logic        auto_en;
   logic        swap;
   logic        pll;
   logic        irq;
   int          fails = 0;
   int          check_count = 0;
   logic [2:0]  codes [4] = '{SPD_10_HALF, SPD_10_FULL, SPD_100_HALF, SPD_100_FULL};
   // control word, strap, then expected {auto, swap, pll}
   pvc_row_t    rows [7] = '{'{16'h0000, 1'h1, 3'h4}, '{16'h0000, 1'h0, 3'h0},
      '{16'h8000, 1'h1, 3'h0}, '{16'ha000, 1'h1, 3'h2}, '{16'hc000, 1'h0, 3'h4},
      '{16'h4000, 1'h0, 3'h0}, '{16'h2400, 1'h1, 3'h5}};

   always #2 i_mclk = ~i_mclk;

   // event sources share one vector, bit position equals flag position
   phy_vendor_ctrl_irq_regs u_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .i_reg_index(idx), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .i_crossover_auto_strap(strap), .i_link_up(~src[4]),
      .i_energy_present(src[7]), .i_rx_polarity_reversed(pol), .i_neg_done(src[6]),
      .i_remote_fault(src[5]), .i_partner_ack(src[3]), .i_parallel_fault(src[2]),
      .i_page_rx(src[1]), .i_resolved_speed_duplex(spd), .o_crossover_auto_en(auto_en),
      .o_crossover_swap(swap), .o_rx_pll_ref_lock_force(pll), .o_phy_irq(irq));

   pvc_mgmt_agent u_agent (.i_mclk(i_mclk), .i_reg_rdata(rdata), .o_reg_index(idx),
      .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      if (fails == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   // one event pulse, then flag and interrupt as seen before and after the read
   task automatic pulse(input int b, input logic irq_exp);
      @(posedge i_mclk);
      src <= 8'h01 << b;
      @(posedge i_mclk);
      src <= 8'h00;
      repeat (2) @(posedge i_mclk);
      check({15'h0, irq}, {15'h0, irq_exp});
      u_agent.reg_read(REG_IRQ_FLAGS, rd_val);
      check(rd_val, 16'h0001 << b);
      check({15'h0, irq}, 16'h0000);
   endtask : pulse

   initial
   begin
      repeat (2) @(posedge i_mclk);
      i_reset_n <= 1'h1;
      u_agent.reg_read(REG_IRQ_FLAGS, rd_val);
      check(rd_val, 16'h0010);
      src <= 8'h00;
      u_agent.reg_read(REG_IRQ_MASK, rd_val);
      check(rd_val, 16'h0000);
      u_agent.reg_read(REG_NEG_STATUS, rd_val);
      check(rd_val, {4'h0, NS_RSV_RESET, SPD_100_FULL, 2'h0});
      foreach (rows[i])
      begin
         strap <= rows[i].strap;
         u_agent.reg_write(REG_XOVER_CTRL, rows[i].wd);
         u_agent.reg_read(REG_XOVER_CTRL, rd_val);
         check({13'h0, auto_en, swap, pll}, {13'h0, rows[i].exp});
         check(rd_val & 16'hfff0, rows[i].wd);
      end
      pol <= 1'h1;
      repeat (2) @(posedge i_mclk);
      u_agent.reg_read(REG_XOVER_CTRL, rd_val);
      check(rd_val & 16'h0010, 16'h0010);
      src <= 8'h40;
      foreach (codes[i])
      begin
         spd <= codes[i];
         repeat (2) @(posedge i_mclk);
         u_agent.reg_read(REG_NEG_STATUS, rd_val);
         check(rd_val, {3'h0, 1'h1, NS_RSV_RESET, codes[i], 2'h0});
      end
      src <= 8'h00;
      u_agent.reg_read(REG_IRQ_FLAGS, rd_val);
      check(rd_val, 16'h0040);
      u_agent.reg_write(REG_IRQ_MASK, 16'hfffe);
      u_agent.reg_read(REG_IRQ_MASK, rd_val);
      check(rd_val, 16'h00fe);
      for (int b = 1; b < 8; b++)
         pulse(b, 1'h1);
      u_agent.reg_write(REG_IRQ_MASK, 16'h00fc);
      pulse(1, 1'h0);
      // status write keeps only the reserved pattern the agent puts back
      u_agent.reg_write(REG_NEG_STATUS, 16'hffff);
      u_agent.reg_read(REG_NEG_STATUS, rd_val);
      check(rd_val, {4'h0, NS_RSV_RESET, SPD_100_FULL, 2'h0});
      // mid-run reset with the line up: link-down flag comes back clear
      i_reset_n <= 1'h0;
      repeat (2) @(posedge i_mclk);
      i_reset_n <= 1'h1;
      u_agent.reg_read(REG_IRQ_MASK, rd_val);
      check(rd_val, 16'h0000);
      check({13'h0, auto_en, swap, pll}, 16'h0004);
      // an event in the clearing read's own cycle must survive it
      fork
         u_agent.reg_read(REG_IRQ_FLAGS, rd_val);
         begin
            @(posedge i_mclk);
            src <= 8'h08;
            @(posedge i_mclk);
            src <= 8'h00;
         end
      join
      check(rd_val, 16'h0000);
      u_agent.reg_read(REG_IRQ_FLAGS, rd_val);
      check(rd_val, 16'h0008);
      check({15'h0, irq}, 16'h0000);
      test_done();
   end

   // hang guard, well beyond the roughly 150 cycles the sequence needs
   initial
   begin
      #20000;
      fails++;
      test_done();
   end
endmodule : test_phy_vendor_ctrl_irq_regs
